//--- hdl/clk_ctrl_consts.svh
// Register map, field positions, reset values and divider constants of the clock control block.
// Notes on behaviour
// (RULE1) After reset main, sub and fast on-chip oscillators stop; slow on-chip one runs.
// (RULE2) Software picks sub clock for a 32.768 kHz external clock, else main.
// (RULE3) External main clock: select main, set main stop bit and pin-switch bit.
// (RULE4) External sub clock: select sub clock and set the sub enable bit.
// (RULE5) Wait stop bit 1 halts peripheral clock in wait mode; 0 keeps it.
// (RULE6) Sub drive bit picks low drive at 0, high drive at 1.
// (RULE7) Sub enable bit stops sub oscillator at 0, runs it at 1.
// (RULE8) Main stop bit stops main clock; external clock input stays accepted.
// (RULE9) Divide-by-8 bit forces divide by 8; else the two-bit ratio applies.
// (RULE10) Fast on-chip oscillator is predivided so the clock stays at most 20 MHz.
// (RULE11) With on-chip clock and no external circuit, oscillator pins become port pins.
// (RULE12) Ratio field: 00 none, 01 by 2, 10 by 4, 11 by 16.
// (RULE13) Clock control writes take effect only while the protect release bit is 1. The code guards CTL0 and CM1 writes only; mode writes always apply.
// (RULE14) Entering stop mode sets divide-by-8 and high sub drive.
// (RULE15) Software may set the sub enable bit but cannot clear it.
// (RULE16) Source or ratio changes never shorten a system clock pulse.
`ifndef CLK_CTRL_CONSTS_SVH
`define CLK_CTRL_CONSTS_SVH

`define CTL0_INDEX       8'h06
`define CM1_INDEX        8'h07
`define CTL0_ADDR        8'h18
`define CM1_ADDR         8'h1c
`define PROT_ADDR        8'h20
`define MODE_ADDR        8'h24
`define STAT_ADDR        8'h28

`define CTL0_RESET       8'h68
`define CM1_RESET        8'h20
`define CTL0_SRC_BIT     1
`define CTL0_WAIT_BIT    2
`define CTL0_DRIVE_BIT   3
`define CTL0_SUBEN_BIT   4
`define CTL0_MSTOP_BIT   5
`define CTL0_DIV8_BIT    6
`define CM1_PINSW_BIT    3
`define CM1_RATIO_LSB    6
`define PROT_BIT         0
`define MODE_ONCHIP_BIT  0
`define MODE_HSSEL_BIT   1
`define MODE_HSEN_BIT    2
`define MODE_LSSTOP_BIT  3
`define MODE_WAIT_BIT    4
`define MODE_STOP_BIT    5

`define DIV8_EDGES       6'h08
`define RATIO0_EDGES     6'h01
`define RATIO1_EDGES     6'h02
`define RATIO2_EDGES     6'h04
`define RATIO3_EDGES     6'h10
`define DIV_SKIP_CNT     6'h3f
`define HS_OSC_KHZ       40000
`define CPU_MAX_KHZ      20000
`define HS_PREDIV        ((`HS_OSC_KHZ + `CPU_MAX_KHZ - 1) / `CPU_MAX_KHZ)

`endif

//--- hdl/clk_ctrl_pkg.sv
// Types shared by the clock control block and its divider.
package clk_ctrl_pkg;

   typedef enum logic [1:0] {SRC_MAIN, SRC_SUB, SRC_HS, SRC_LS} src_t;

   typedef struct packed {
      logic src_sub;
      logic wait_stop;
      logic sub_drive;
      logic sub_en;
      logic main_stop;
      logic div8;
   } ctl0_t;

   typedef struct packed {
      logic onchip;
      logic hs_sel;
      logic hs_en;
      logic ls_stop;
      logic wait_mode;
      logic stop;
   } mode_t;

   typedef struct packed {
      logic        hready;
      logic        hresp;
      logic [31:0] hrdata;
      logic        dp_wr;
      logic [7:0]  dp_addr;
      ctl0_t       ctl0;
      logic        pin_sw;
      logic [1:0]  ratio;
      logic        prot;
      mode_t       mode;
      logic        stop_prev;
      logic [3:0]  sync1;
      logic [3:0]  sync2;
      logic        main_osc_en;
      logic        sub_osc_en;
      logic        sub_drive_high;
      logic        hs_osc_en;
      logic        ls_osc_en;
      logic        periph_clk_en;
      logic        port_pin_mode;
      logic [5:0]  req_edges;
      src_t        src;
   } top_state_t;

   typedef struct packed {
      logic [3:0] prev;
      logic [5:0] cnt;
      logic       clk_lvl;
      logic [5:0] edges;
      src_t       sel;
   } div_state_t;

endpackage

//--- hdl/clk_sel_if.sv
// Carrier between the control registers and the system clock divider.
`timescale 1ns/1ns
interface clk_sel_if;
   logic [3:0]         src_lvl;
   clk_ctrl_pkg::src_t sel;
   logic [5:0]         edges;
   logic               sys_clk;
   clk_ctrl_pkg::src_t cur_sel;
   logic [5:0]         cur_edges;

   modport ctl (output src_lvl, output sel, output edges,
                input sys_clk, input cur_sel, input cur_edges);
   modport gen (input src_lvl, input sel, input edges,
                output sys_clk, output cur_sel, output cur_edges);
endinterface

//--- hdl/sys_clk_divider.sv
// System clock generator: divides the selected source and switches only while low.
`timescale 1ns/1ns
`include "clk_ctrl_consts.svh"
module sys_clk_divider
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Control side.
   clk_sel_if.gen   ctl
);
   clk_ctrl_pkg::div_state_t d_r;
   clk_ctrl_pkg::div_state_t d_nxt;
   localparam clk_ctrl_pkg::div_state_t DIV_RST =
      '{prev: 4'h0, cnt: 6'h00, clk_lvl: 1'b0, edges: `DIV8_EDGES, sel: clk_ctrl_pkg::SRC_LS};

   always_comb
   begin
      d_nxt = d_r;
      d_nxt.prev = ctl.src_lvl;
      // Both edges of the source count, so a count of N gives N source periods.
      if (ctl.src_lvl[d_r.sel] != d_r.prev[d_r.sel])
      begin
         if (d_r.cnt + 6'h01 >= d_r.edges)
         begin
            d_nxt.cnt = 6'h00;
            d_nxt.clk_lvl = ~d_r.clk_lvl;
         end
         else
         begin
            d_nxt.cnt = d_r.cnt + 6'h01;
         end
      end
      // A new setting is taken only at the start of a low phase.
      if (!d_nxt.clk_lvl && d_nxt.cnt == 6'h00)
      begin
         d_nxt.sel = ctl.sel; // RULE16
         d_nxt.edges = (ctl.edges == 6'h00) ? 6'h01 : ctl.edges;
         // A new source starts at an unknown phase, so its first edge is not counted.
         if (ctl.sel != d_r.sel)
            d_nxt.cnt = `DIV_SKIP_CNT; // RULE16
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         d_r <= DIV_RST;
      else
         d_r <= d_nxt;
   end

   assign ctl.sys_clk = d_r.clk_lvl;
   assign ctl.cur_sel = d_r.sel;
   assign ctl.cur_edges = d_r.edges;

   property p_switch_low;
      @(posedge clk) disable iff (!rst_b)
      ($changed(d_r.edges) || $changed(d_r.sel)) |-> !d_r.clk_lvl
         && d_r.cnt == ($changed(d_r.sel) ? `DIV_SKIP_CNT : 6'h00);
   endproperty
   a_switch_low: assert property (p_switch_low) else $error("divider setting changed mid-pulse"); // RULE16
endmodule

//--- hdl/system_clock_source_control.sv
// Clock source selection and control registers behind an AHB-Lite slave.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ns
`include "clk_ctrl_consts.svh"
module system_clock_source_control
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst_b,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Oscillator clock inputs.
   input  wire logic        main_osc_input,
   input  wire logic        sub_osc_input,
   input  wire logic        hs_osc_clk,
   input  wire logic        ls_osc_clk,
   // Oscillator and clock controls.
   output logic             main_osc_en,
   output logic             sub_osc_en,
   output logic             sub_drive_high,
   output logic             hs_osc_en,
   output logic             ls_osc_en,
   output logic             periph_clk_en,
   output logic             port_pin_mode,
   output logic             sys_clk_out
);
   localparam logic [7:0] CTL0_RV = `CTL0_RESET;
   localparam logic [7:0] CM1_RV = `CM1_RESET;
   localparam clk_ctrl_pkg::top_state_t TOP_RST = '{
      hready: 1'b1, hresp: 1'b0, hrdata: 32'h0000_0000, dp_wr: 1'b0, dp_addr: 8'h00,
      ctl0: '{src_sub: CTL0_RV[`CTL0_SRC_BIT], wait_stop: CTL0_RV[`CTL0_WAIT_BIT],
             sub_drive: CTL0_RV[`CTL0_DRIVE_BIT], sub_en: CTL0_RV[`CTL0_SUBEN_BIT],
             main_stop: CTL0_RV[`CTL0_MSTOP_BIT], div8: CTL0_RV[`CTL0_DIV8_BIT]},
      pin_sw: CM1_RV[`CM1_PINSW_BIT], ratio: CM1_RV[`CM1_RATIO_LSB +: 2], prot: 1'b0,
      mode: '{onchip: 1'b1, hs_sel: 1'b0, hs_en: 1'b0, ls_stop: 1'b0,
              wait_mode: 1'b0, stop: 1'b0},
      stop_prev: 1'b0, sync1: 4'h0, sync2: 4'h0,
      main_osc_en: 1'b0, sub_osc_en: 1'b0, sub_drive_high: 1'b1, hs_osc_en: 1'b0,
      ls_osc_en: 1'b1, periph_clk_en: 1'b1, port_pin_mode: 1'b1,
      req_edges: `DIV8_EDGES, src: clk_ctrl_pkg::SRC_LS};

   clk_ctrl_pkg::top_state_t s_r;
   clk_ctrl_pkg::top_state_t s_nxt;
   clk_ctrl_pkg::src_t       src_now;
   logic [5:0]               base_edges;
   logic                     stop_enter;
   logic                     addr_phase;

   clk_sel_if ctl_if ();

   sys_clk_divider divider
   (
      .clk   (clk),
      .rst_b (rst_b),
      .ctl   (ctl_if.gen)
   );

   assign addr_phase = hsel && htrans[1] && hready;
   assign stop_enter = s_r.mode.stop && !s_r.stop_prev;

   always_comb
   begin
      if (s_r.mode.onchip)
         src_now = s_r.mode.hs_sel ? clk_ctrl_pkg::SRC_HS : clk_ctrl_pkg::SRC_LS;
      else
         src_now = s_r.ctl0.src_sub ? clk_ctrl_pkg::SRC_SUB : clk_ctrl_pkg::SRC_MAIN;
   end

   always_comb
   begin
      if (s_r.ctl0.div8)
         base_edges = `DIV8_EDGES; // RULE9
      else
      begin
         unique case (s_r.ratio) // RULE12
            2'b00: base_edges = `RATIO0_EDGES;
            2'b01: base_edges = `RATIO1_EDGES;
            2'b10: base_edges = `RATIO2_EDGES;
            2'b11: base_edges = `RATIO3_EDGES;
         endcase
      end
   end

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.hready = 1'b1;
      s_nxt.hresp = 1'b0;
      s_nxt.sync1 = {ls_osc_clk, hs_osc_clk, sub_osc_input, main_osc_input};
      s_nxt.sync2 = s_r.sync1;
      s_nxt.stop_prev = s_r.mode.stop;
      if (s_r.dp_wr)
      begin
         unique case (s_r.dp_addr)
            `CTL0_ADDR:
               if (s_r.prot) // RULE13
               begin
                  s_nxt.ctl0.src_sub = hwdata[`CTL0_SRC_BIT];
                  s_nxt.ctl0.wait_stop = hwdata[`CTL0_WAIT_BIT];
                  s_nxt.ctl0.sub_drive = hwdata[`CTL0_DRIVE_BIT];
                  s_nxt.ctl0.sub_en = s_r.ctl0.sub_en | hwdata[`CTL0_SUBEN_BIT]; // RULE15
                  s_nxt.ctl0.main_stop = hwdata[`CTL0_MSTOP_BIT];
                  s_nxt.ctl0.div8 = hwdata[`CTL0_DIV8_BIT];
               end
            `CM1_ADDR:
               if (s_r.prot) // RULE13
               begin
                  s_nxt.pin_sw = s_r.pin_sw | hwdata[`CM1_PINSW_BIT];
                  s_nxt.ratio = hwdata[`CM1_RATIO_LSB +: 2];
               end
            `PROT_ADDR: s_nxt.prot = hwdata[`PROT_BIT];
            `MODE_ADDR:
            begin
               s_nxt.mode.onchip = hwdata[`MODE_ONCHIP_BIT];
               s_nxt.mode.hs_sel = hwdata[`MODE_HSSEL_BIT];
               s_nxt.mode.hs_en = hwdata[`MODE_HSEN_BIT];
               s_nxt.mode.ls_stop = hwdata[`MODE_LSSTOP_BIT];
               s_nxt.mode.wait_mode = hwdata[`MODE_WAIT_BIT];
               s_nxt.mode.stop = hwdata[`MODE_STOP_BIT];
            end
            default: ;
         endcase
      end
      // Stop-mode entry overrides a write landing in the same cycle.
      if (stop_enter)
      begin
         s_nxt.ctl0.div8 = 1'b1; // RULE14
         s_nxt.ctl0.sub_drive = 1'b1; // RULE14
      end
      s_nxt.main_osc_en = !s_r.ctl0.main_stop; // RULE8
      s_nxt.sub_osc_en = s_r.ctl0.sub_en; // RULE7
      s_nxt.sub_drive_high = s_r.ctl0.sub_drive; // RULE6
      s_nxt.hs_osc_en = s_r.mode.hs_en; // RULE1
      s_nxt.ls_osc_en = !s_r.mode.ls_stop; // RULE1
      s_nxt.periph_clk_en = !(s_r.mode.wait_mode && s_r.ctl0.wait_stop); // RULE5
      s_nxt.port_pin_mode = s_r.mode.onchip && !s_r.ctl0.sub_en && s_r.ctl0.main_stop
                            && !s_r.pin_sw; // RULE11
      s_nxt.src = src_now;
      if (src_now == clk_ctrl_pkg::SRC_HS)
         s_nxt.req_edges = 6'(base_edges * `HS_PREDIV); // RULE10
      else
         s_nxt.req_edges = base_edges;
      s_nxt.dp_wr = addr_phase && hwrite;
      s_nxt.dp_addr = haddr[7:0];
      // Reads use the post-write values so a read right after a write sees it.
      if (addr_phase && !hwrite)
      begin
         s_nxt.hrdata = 32'h0000_0000;
         unique case (haddr[7:0])
            `CTL0_ADDR: s_nxt.hrdata[7:0] = {1'b0, s_nxt.ctl0.div8, s_nxt.ctl0.main_stop,
                                            s_nxt.ctl0.sub_en, s_nxt.ctl0.sub_drive,
                                            s_nxt.ctl0.wait_stop, s_nxt.ctl0.src_sub, 1'b0};
            `CM1_ADDR: s_nxt.hrdata[7:0] = {s_nxt.ratio, 2'b00, s_nxt.pin_sw, 3'b000};
            `PROT_ADDR: s_nxt.hrdata[`PROT_BIT] = s_nxt.prot;
            `MODE_ADDR: s_nxt.hrdata[5:0] = {s_nxt.mode.stop, s_nxt.mode.wait_mode,
                                            s_nxt.mode.ls_stop, s_nxt.mode.hs_en,
                                            s_nxt.mode.hs_sel, s_nxt.mode.onchip};
            `STAT_ADDR: s_nxt.hrdata[10:0] = {s_r.periph_clk_en, s_r.port_pin_mode,
                                             ctl_if.cur_edges, ctl_if.cur_sel,
                                             ctl_if.sys_clk};
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         s_r <= TOP_RST;
      else
         s_r <= s_nxt;
   end

   // Gated source levels; an external main clock passes while the pin switch is set.
   assign ctl_if.src_lvl = {s_r.sync2[3] & !s_r.mode.ls_stop, s_r.sync2[2] & s_r.mode.hs_en,
                            s_r.sync2[1] & s_r.ctl0.sub_en,
                            s_r.sync2[0] & (!s_r.ctl0.main_stop | s_r.pin_sw)}; // RULE8
   assign ctl_if.sel = s_r.src;
   assign ctl_if.edges = s_r.req_edges;

   assign hreadyout = s_r.hready;
   assign hresp = s_r.hresp;
   assign hrdata = s_r.hrdata;
   assign main_osc_en = s_r.main_osc_en;
   assign sub_osc_en = s_r.sub_osc_en;
   assign sub_drive_high = s_r.sub_drive_high;
   assign hs_osc_en = s_r.hs_osc_en;
   assign ls_osc_en = s_r.ls_osc_en;
   assign periph_clk_en = s_r.periph_clk_en;
   assign port_pin_mode = s_r.port_pin_mode;
   assign sys_clk_out = ctl_if.sys_clk;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_ctl0_wr;
      s_r.dp_wr && s_r.dp_addr == `CTL0_ADDR && s_r.prot && !stop_enter && !s_r.mode.stop;
   endsequence
   sequence s_ctl0_apply;
      ##1 !stop_enter ##1 1'b1;
   endsequence

   property p_reset_state;
      $rose(rst_b) |-> !main_osc_en && !sub_osc_en && !hs_osc_en && ls_osc_en;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("oscillators wrong after reset"); // RULE1
   property p_periph_stop;
      (s_r.mode.wait_mode && s_r.ctl0.wait_stop) |=> !periph_clk_en;
   endproperty
   a_periph_stop: assert property (p_periph_stop) else $error("peripheral clock not stopped"); // RULE5
   property p_sub_drive;
      s_ctl0_wr ##0 s_ctl0_apply |-> sub_drive_high == $past(hwdata[`CTL0_DRIVE_BIT], 2);
   endproperty
   a_sub_drive: assert property (p_sub_drive) else $error("sub drive does not follow write"); // RULE6
   property p_sub_enable;
      (s_ctl0_wr ##0 hwdata[`CTL0_SUBEN_BIT]) |=> ##1 sub_osc_en;
   endproperty
   a_sub_enable: assert property (p_sub_enable) else $error("sub oscillator not enabled"); // RULE7
   property p_sub_sticky;
      s_r.ctl0.sub_en |=> s_r.ctl0.sub_en;
   endproperty
   a_sub_sticky: assert property (p_sub_sticky) else $error("sub enable was cleared"); // RULE15
   property p_main_stop;
      s_ctl0_wr |=> ##1 main_osc_en == !$past(hwdata[`CTL0_MSTOP_BIT], 2);
   endproperty
   a_main_stop: assert property (p_main_stop) else $error("main enable does not follow write"); // RULE8
   property p_div8;
      (s_r.ctl0.div8 && src_now != clk_ctrl_pkg::SRC_HS) |=> s_r.req_edges == `DIV8_EDGES;
   endproperty
   a_div8: assert property (p_div8) else $error("divide-by-8 not applied"); // RULE9
   property p_ratio16;
      (!s_r.ctl0.div8 && s_r.ratio == 2'b11 && src_now != clk_ctrl_pkg::SRC_HS)
         |=> s_r.req_edges == `RATIO3_EDGES;
   endproperty
   a_ratio16: assert property (p_ratio16) else $error("divide-by-16 not applied"); // RULE12
   property p_hs_limit;
      (src_now == clk_ctrl_pkg::SRC_HS && !s_r.ctl0.div8 && s_r.ratio == 2'b00)
         |=> s_r.req_edges == 6'(`HS_PREDIV);
   endproperty
   a_hs_limit: assert property (p_hs_limit) else $error("fast oscillator not predivided"); // RULE10
   property p_gpio;
      (s_r.mode.onchip && !s_r.ctl0.sub_en && s_r.ctl0.main_stop && !s_r.pin_sw)
         |=> port_pin_mode;
   endproperty
   a_gpio: assert property (p_gpio) else $error("pins not released to port"); // RULE11
   property p_protect;
      (s_r.dp_wr && s_r.dp_addr == `CTL0_ADDR && !s_r.prot && !stop_enter)
         |=> $stable(s_r.ctl0);
   endproperty
   a_protect: assert property (p_protect) else $error("protected write took effect"); // RULE13
   property p_stop_entry;
      stop_enter |=> s_r.ctl0.div8 && s_r.ctl0.sub_drive;
   endproperty
   a_stop_entry: assert property (p_stop_entry) else $error("stop entry did not force bits"); // RULE14
endmodule

//--- sim/osc_source_model.sv
// Behavioural oscillators and external clock sources feeding the clock control block.
`timescale 1ns/1ns
module osc_source_model
#(
   parameter int main_half = 200,
   parameter int sub_half  = 600,
   parameter int hs_half   = 120,
   parameter int ls_half   = 300
)
(
   // Enables from the block.
   input  wire logic main_osc_en,
   input  wire logic sub_osc_en,
   input  wire logic hs_osc_en,
   input  wire logic ls_osc_en,
   // External clock on the main oscillator input.
   input  wire logic ext_main,
   // Oscillator clock levels.
   output logic      main_osc_input,
   output logic      sub_osc_input,
   output logic      hs_osc_clk,
   output logic      ls_osc_clk
);
   // A stopped oscillator stands still low instead of holding its last level.
   initial
   begin
      main_osc_input = 1'b0;
      sub_osc_input = 1'b0;
      hs_osc_clk = 1'b0;
      ls_osc_clk = 1'b0;
   end
   // An external clock keeps running even while the buffer is switched off.
   always #main_half main_osc_input = (main_osc_en || ext_main) ? ~main_osc_input : 1'b0;
   always #sub_half sub_osc_input = sub_osc_en ? ~sub_osc_input : 1'b0;
   always #hs_half hs_osc_clk = hs_osc_en ? ~hs_osc_clk : 1'b0;
   always #ls_half ls_osc_clk = ls_osc_en ? ~ls_osc_clk : 1'b0;
endmodule

//--- sim/system_clock_source_control_tb_top.sv
// Self-checking bench for the clock source control block.
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
   begin \
      n_compared++; \
      if ((got) !== (ex)) \
      begin \
         err_total++; \
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
      end \
   end
module system_clock_source_control_tb_top;
   localparam logic [31:0] ctl0_addr = 32'h0000_0018;
   localparam logic [31:0] ctl1_addr = 32'h0000_001c;
   localparam logic [31:0] prot_addr = 32'h0000_0020;
   localparam logic [31:0] mode_addr = 32'h0000_0024;
   localparam int          main_half = 200;
   localparam int          sub_half  = 600;
   localparam int          hs_half   = 120;
   localparam int          ls_half   = 300;
   logic        clk, rst_b, hsel, hwrite, hready, hreadyout, hresp, ext_main;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        main_osc_input, sub_osc_input, hs_osc_clk, ls_osc_clk;
   logic        main_osc_en, sub_osc_en, sub_drive_high, hs_osc_en, ls_osc_en;
   logic        periph_clk_en, port_pin_mode, sys_clk_out;
   int          err_total, n_compared;
   int          ratio_mul [4] = '{1, 2, 4, 16};
   time         last_edge, min_width;

   assign hready = hreadyout;

   system_clock_source_control dut_u (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .main_osc_input(main_osc_input),
      .sub_osc_input(sub_osc_input), .hs_osc_clk(hs_osc_clk), .ls_osc_clk(ls_osc_clk),
      .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en), .sub_drive_high(sub_drive_high),
      .hs_osc_en(hs_osc_en), .ls_osc_en(ls_osc_en), .periph_clk_en(periph_clk_en),
      .port_pin_mode(port_pin_mode), .sys_clk_out(sys_clk_out));

   osc_source_model #(.main_half(main_half), .sub_half(sub_half), .hs_half(hs_half),
      .ls_half(ls_half)) osc_u (.main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
      .hs_osc_en(hs_osc_en), .ls_osc_en(ls_osc_en), .ext_main(ext_main),
      .main_osc_input(main_osc_input), .sub_osc_input(sub_osc_input),
      .hs_osc_clk(hs_osc_clk), .ls_osc_clk(ls_osc_clk));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Track the narrowest system clock phase seen after reset.
   always @(sys_clk_out)
   begin
      if (rst_b === 1'b1 && $time - last_edge < min_width)
         min_width = $time - last_edge;
      last_edge = $time;
   end

   task automatic complete_run();
      if (err_total == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge clk);
      while (hready !== 1'b1 && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 100)
         err_total++;
   endtask

   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
   endtask

   task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] ex);
      xfer(1'b0, a, 32'h0000_0000);
      `CHK(nm, ex, hrdata)
      `CHK("hresp", 1'b0, hresp)
   endtask

   task automatic settle();
      repeat (3) @(posedge clk);
   endtask

   task automatic wait_rise();
      int n;
      n = 0;
      while (sys_clk_out !== 1'b0 && n < 4000)
      begin
         @(posedge clk);
         n++;
      end
      while (sys_clk_out !== 1'b1 && n < 4000)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 4000)
         err_total++;
   endtask

   // The first two rises let the new selection land; the period from the second to the third rise is measured.
   task automatic measure(input string nm, input int ex);
      time t1;
      int  dt;
      wait_rise();
      wait_rise();
      t1 = $time;
      wait_rise();
      dt = int'($time - t1);
      `CHK(nm, 1'b1, (dt <= ex + 40) && (dt + 40 >= ex))
   endtask

   initial
   begin
      #1000000;
      err_total++;
      complete_run();
   end

   initial
   begin
      rst_b = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      ext_main = 1'b0;
      err_total = 0;
      n_compared = 0;
      last_edge = 0;
      min_width = 1000000;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      `CHK("main_osc_en", 1'b0, main_osc_en)
      `CHK("sub_osc_en", 1'b0, sub_osc_en)
      `CHK("hs_osc_en", 1'b0, hs_osc_en)
      `CHK("ls_osc_en", 1'b1, ls_osc_en)
      `CHK("port_pin_mode", 1'b1, port_pin_mode)
      `CHK("sub_drive_high", 1'b1, sub_drive_high)
      `CHK("periph_clk_en", 1'b1, periph_clk_en)
      rd("ctl0 reset", ctl0_addr, 32'h0000_0068);
      rd("ctl1 reset", ctl1_addr, 32'h0000_0000);
      rd("mode reset", mode_addr, 32'h0000_0001);
      xfer(1'b1, ctl0_addr, 32'h0000_0000);
      rd("ctl0 locked", ctl0_addr, 32'h0000_0068);
      xfer(1'b1, prot_addr, 32'h0000_0001);
      xfer(1'b1, ctl0_addr, 32'h0000_0060);
      settle();
      `CHK("sub_drive_high", 1'b0, sub_drive_high)
      rd("ctl0 drive", ctl0_addr, 32'h0000_0060);
      xfer(1'b1, ctl0_addr, 32'h0000_006c);
      xfer(1'b1, mode_addr, 32'h0000_0011);
      settle();
      `CHK("periph_clk_en", 1'b0, periph_clk_en)
      xfer(1'b1, ctl0_addr, 32'h0000_0068);
      settle();
      `CHK("periph_clk_en", 1'b1, periph_clk_en)
      xfer(1'b1, mode_addr, 32'h0000_0001);
      xfer(1'b1, ctl1_addr, 32'h0000_00c0);
      xfer(1'b1, ctl0_addr, 32'h0000_0048);
      settle();
      `CHK("main_osc_en", 1'b1, main_osc_en)
      xfer(1'b1, mode_addr, 32'h0000_0000);
      measure("div8 period", 8 * 2 * main_half);
      xfer(1'b1, ctl0_addr, 32'h0000_0008);
      for (int r = 0; r < 4; r++)
      begin
         xfer(1'b1, ctl1_addr, 32'(r) << 6);
         measure("ratio period", ratio_mul[r] * 2 * main_half);
      end
      xfer(1'b1, ctl1_addr, 32'h0000_0000);
      xfer(1'b1, mode_addr, 32'h0000_0007);
      settle();
      `CHK("hs_osc_en", 1'b1, hs_osc_en)
      `CHK("port_pin_mode", 1'b0, port_pin_mode)
      measure("fast period", 2 * 2 * hs_half);
      xfer(1'b1, ctl0_addr, 32'h0000_003a);
      xfer(1'b1, mode_addr, 32'h0000_0000);
      settle();
      `CHK("sub_osc_en", 1'b1, sub_osc_en)
      measure("sub period", 2 * sub_half);
      xfer(1'b1, ctl0_addr, 32'h0000_002a);
      settle();
      `CHK("sub_osc_en", 1'b1, sub_osc_en)
      rd("ctl0 sub set", ctl0_addr, 32'h0000_003a);
      ext_main <= 1'b1;
      xfer(1'b1, ctl0_addr, 32'h0000_0038);
      xfer(1'b1, ctl1_addr, 32'h0000_0008);
      settle();
      `CHK("main_osc_en", 1'b0, main_osc_en)
      measure("ext period", 2 * main_half);
      rd("unmapped", 32'h0000_0040, 32'h0000_0000);
      xfer(1'b1, ctl0_addr, 32'h0000_0030);
      rd("ctl0 pre stop", ctl0_addr, 32'h0000_0030);
      xfer(1'b1, mode_addr, 32'h0000_0020);
      rd("ctl0 stop", ctl0_addr, 32'h0000_0078);
      settle();
      `CHK("sub_drive_high", 1'b1, sub_drive_high)
      `CHK("min pulse", 1'b1, min_width >= 160)
      complete_run();
   end
endmodule
